// ===== src/gmc_gpio_override.sv
// Mode selection and converter override for three open-drain pins.
// Assumes configuration bits come straight from a register file and
// pin inputs may be asynchronous to clk_sys and pass two sync stages here.
`timescale 1ns/100ps
module gmc_gpio_override
  import gmc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  // Pins (open drain)
  input  wire logic [2:0] pin_in,
  output logic      [2:0] pin_out,
  output logic      [2:0] pin_oe,
  // Pin one and two configuration
  input  wire logic       pin_one_direction,
  input  wire logic       pin_one_out_level,
  input  wire logic       pin_one_irq_enable,
  input  wire logic       pin_one_level_select,
  input  wire logic       pin_one_buck_one_ctrl,
  input  wire logic       pin_one_standby_ctrl,
  input  wire logic       pin_two_direction,
  input  wire logic       pin_two_out_level,
  input  wire logic       pin_two_irq_enable,
  input  wire logic       pin_two_level_select,
  input  wire logic       pin_two_buck_two_ctrl,
  // Pin three configuration
  input  wire logic       pin_three_direction,
  input  wire logic       pin_three_out_level,
  input  wire logic       conv_trigger_enable,
  input  wire logic       conv_trigger_edge_select,
  // Host commands and system events
  input  wire logic       host_buck_one_on,
  input  wire logic       host_buck_two_on,
  input  wire logic       host_standby,
  input  wire logic       host_read,
  input  wire logic       undervoltage_lockout,
  // Results
  output logic            buck_one_on,
  output logic            buck_two_on,
  output logic            buck_standby,
  output logic            conv_start,
  output logic            irq_n
);

  // All state lives in one packed struct so that a single register
  // process owns every flip-flop; clk_en then freezes the whole block
  // at once and no field can slip out of step with the others.
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    gmc_irq_e   irq1;
    gmc_irq_e   irq2;
    logic [2:0] out;
    logic [2:0] oe;
    logic       b1;
    logic       b2;
    logic       sby;
    logic       conv;
    logic       irq_n;
  } gmc_state_s;

  // Decode helpers below are plain combinational nets, not state
  gmc_state_s st_r;
  gmc_state_s st_nxt;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] dir;
  logic [2:0] lvl;
  logic       ev1;
  logic       ev2;
  logic       en1;
  logic       en2;
  logic       gp_b1;
  logic       gp_b2;
  logic       gp_sby;

  // Direction and level bits gathered per pin, bit 0 being pin one,
  // so the open-drain enables can be formed as one vector
  assign dir = {pin_three_direction, pin_two_direction, pin_one_direction};
  assign lvl = {pin_three_out_level, pin_two_out_level, pin_one_out_level};

  // edge compare, per pin
  // Edge seen in the same clock that the second stage takes the new level
  genvar g;
  generate
    for (g = 0; g < GMC_PINS; g++) begin : g_edge
      assign rise[g] = st_r.sync2[g] & ~st_r.prev[g];
      assign fall[g] = ~st_r.sync2[g] & st_r.prev[g];
    end
  endgenerate

  // Interrupt latch step: set on first edge, arm on second, clear on read
  // The latch only leaves the idle state on a qualifying edge. A read
  // that arrives while the latch holds only the first edge is ignored,
  // so a host that reads too early sees the line stay low; it must
  // wait for the second edge and read again.
  // A read in the same cycle as a fresh edge is ignored too, so the
  // edge is never lost behind the read.
  function automatic gmc_irq_e irq_step(gmc_irq_e cur, logic en,
                                        logic ev, logic clr,
                                        logic rd);
    gmc_irq_e n;
    n = cur;
    if (clr || !en) begin
      n = GMC_IRQ_IDLE;
    end else begin
      case (cur)
        GMC_IRQ_IDLE:  n = ev ? GMC_IRQ_SET : GMC_IRQ_IDLE;
        GMC_IRQ_SET:   n = ev ? GMC_IRQ_ARMED : GMC_IRQ_SET;
        GMC_IRQ_ARMED: n = (rd && !ev) ? GMC_IRQ_IDLE
                                              : GMC_IRQ_ARMED;
        default:       n = GMC_IRQ_IDLE;
      endcase
    end
    return n;
  endfunction

  // Mode decode and next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = pin_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev  = st_r.sync2;
    // pin one edge; level select one picks falling
    en1 = !pin_one_direction && pin_one_irq_enable &&
          !pin_one_buck_one_ctrl && !pin_one_standby_ctrl;
    ev1 = en1 && (pin_one_level_select ? fall[GMC_P1] : rise[GMC_P1]);
    // pin two edge, same polarity convention
    en2 = !pin_two_direction && pin_two_irq_enable && !pin_two_buck_two_ctrl;
    ev2 = en2 && (pin_two_level_select ? fall[GMC_P2] : rise[GMC_P2]);
    st_nxt.irq1 = irq_step(st_r.irq1, en1, ev1, undervoltage_lockout,
                           host_read);
    st_nxt.irq2 = irq_step(st_r.irq2, en2, ev2, undervoltage_lockout,
                           host_read);
    // Line low while either latch holds a request
    st_nxt.irq_n = (st_nxt.irq1 == GMC_IRQ_IDLE) &&
                   (st_nxt.irq2 == GMC_IRQ_IDLE);
    // When a pin is not in its converter mode its command is neutral:
    // enable for on/off, so the host alone decides, and not-standby for
    // standby, which keeps standby off. Mixed settings that break the one-function rule fall
    // back to this neutral command rather than to a guess.
    // pin one drives converter one by level
    gp_b1 = 1'b1;
    if (!pin_one_direction && !pin_one_irq_enable &&
        pin_one_buck_one_ctrl && !pin_one_standby_ctrl) begin
      gp_b1 = (st_r.sync2[GMC_P1] == pin_one_level_select);
    end
    // pin two drives converter two by level
    gp_b2 = 1'b1;
    if (!pin_two_direction && !pin_two_irq_enable &&
        pin_two_buck_two_ctrl) begin
      gp_b2 = (st_r.sync2[GMC_P2] == pin_two_level_select);
    end
    gp_sby = 1'b0;
    if (!pin_one_direction && !pin_one_irq_enable &&
        !pin_one_buck_one_ctrl && pin_one_standby_ctrl) begin
      gp_sby = (st_r.sync2[GMC_P1] == pin_one_level_select);
    end
    st_nxt.b1 = host_buck_one_on && gp_b1;
    st_nxt.b2 = host_buck_two_on && gp_b2;
    st_nxt.sby = host_standby && gp_sby;
    // conversion trigger; edge select one picks rising
    st_nxt.conv = !pin_three_direction && conv_trigger_enable &&
                  (conv_trigger_edge_select ? rise[GMC_P3] : fall[GMC_P3]);
    // The pads are open drain: the data bit is always zero and only
    // the enable moves, so the line can never be driven high.
    // open drain: enable pulls low when level bit is zero
    st_nxt.out = 3'h0;
    st_nxt.oe  = dir & ~lvl;
  end

  // Synchroniser stages reset to one because the pins idle high on
  // their pull-ups; a pin held low through reset therefore shows a
  // falling edge a few clocks after release, which a user in
  // falling-edge mode will see as a real event.
  // State register; clock enable freezes everything
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r       <= '0;
      st_r.sync1 <= GMC_SYNC_RST;
      st_r.sync2 <= GMC_SYNC_RST;
      st_r.prev  <= GMC_SYNC_RST;
      st_r.irq_n <= GMC_IRQ_RST_N;
      st_r.oe    <= {GMC_PINS{GMC_OE_RST}};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Every result leaves straight from the state register. Latency from
  // a pin change to conv_start, irq_n or the converter commands is three
  // clocks, counting the two sampling stages.
  assign pin_out      = st_r.out;
  assign pin_oe       = st_r.oe;
  assign buck_one_on  = st_r.b1;
  assign buck_two_on  = st_r.b2;
  assign buck_standby = st_r.sby;
  assign conv_start   = st_r.conv;
  assign irq_n        = st_r.irq_n;

endmodule

// ===== src/gmc_pkg.sv
// Package for the pin mode and converter override block.
// Assumes one system clock and an active-low asynchronous reset.
package gmc_pkg;
  localparam int GMC_PINS = 3;
  // Pin indices
  localparam int GMC_P1 = 0;
  localparam int GMC_P2 = 1;
  localparam int GMC_P3 = 2;
  // Values after reset
  localparam logic [2:0] GMC_SYNC_RST  = 3'h7;  // Pins idle high
  localparam logic       GMC_IRQ_RST_N = 1'h1;
  localparam logic       GMC_OE_RST    = 1'h0;
  // Interrupt latch states
  typedef enum logic [1:0] {
    GMC_IRQ_IDLE  = 2'b00,
    GMC_IRQ_SET   = 2'b01,
    GMC_IRQ_ARMED = 2'b10
  } gmc_irq_e;
endpackage

// ===== verif/gmc_pin_model.sv
// Far side of the three open-drain pins.
// Assumes pin_oe high means the block pulls the line low.
`timescale 1ns/100ps
module gmc_pin_model (
  // From the block and the bench
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] ext_low,
  // Resolved line level
  output logic     [2:0] pin_level
);
  // Pull-ups win unless either party pulls low
  assign pin_level = ~(pin_oe | ext_low);
endmodule

// ===== verif/gmc_props.sv
// Port checker for the pin mode and converter override block.
// Assumes clk_en is held high and reset is resetn.
`timescale 1ns/100ps
module gmc_props (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // Pins and configuration
  input wire logic [2:0] pin_in,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic       pin_one_direction,
  input wire logic       pin_one_out_level,
  input wire logic       pin_two_buck_two_ctrl,
  input wire logic       pin_two_level_select,
  input wire logic       pin_two_direction,
  input wire logic       pin_two_irq_enable,
  // Commands and results
  input wire logic       host_buck_one_on,
  input wire logic       host_buck_two_on,
  input wire logic       host_standby,
  input wire logic       buck_one_on,
  input wire logic       buck_two_on,
  input wire logic       buck_standby,
  input wire logic       conv_start
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  chk_oe_follow: assert property ($past(resetn) |->
    pin_oe[0] == $past(pin_one_direction & ~pin_one_out_level))
    else $error("pin one enable wrong");
  chk_od_low: assert property (pin_out == 3'h0)
    else $error("pin driven high");
  chk_host_one: assert property (!host_buck_one_on |=> !buck_one_on)
    else $error("converter one on");
  chk_host_two: assert property (!host_buck_two_on |=> !buck_two_on)
    else $error("converter two on");
  chk_host_sby: assert property (!host_standby |=> !buck_standby)
    else $error("standby set");
  chk_conv_once: assert property (conv_start |=> !conv_start)
    else $error("trigger too long");
  // Bench spaces pin three edges at least twelve cycles apart
  chk_conv_edge: assert property (conv_start |->
    $past(pin_in[2]) != $past(pin_in[2], 8))
    else $error("trigger without edge");
  // Output at an edge reflects the pin three clocks back, mode one clock back
  chk_buck_two: assert property (buck_two_on &&
    $past(pin_two_buck_two_ctrl & ~pin_two_direction & ~pin_two_irq_enable)
    |-> $past(pin_in[1], 3) == $past(pin_two_level_select))
    else $error("converter two level");
endmodule
bind gmc_gpio_override gmc_props u_gmc_props (.clk_sys, .resetn, .pin_in,
  .pin_out, .pin_oe, .pin_one_direction, .pin_one_out_level,
  .pin_two_buck_two_ctrl, .pin_two_level_select, .pin_two_direction,
  .pin_two_irq_enable, .host_buck_one_on,
  .host_buck_two_on, .host_standby, .buck_one_on, .buck_two_on,
  .buck_standby, .conv_start);

// ===== verif/tb.sv
// Self-checking bench for the pin mode and converter override block.
// Assumes the checker is bound in; clk_en stays high.
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_fail++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  logic clk_sys, resetn, clk_en, host_read, undervoltage_lockout;
  logic [2:0] pin_in, pin_out, pin_oe, ext_low;
  logic pin_one_direction, pin_one_out_level, pin_one_irq_enable;
  logic pin_one_level_select, pin_one_buck_one_ctrl, pin_one_standby_ctrl;
  logic pin_two_direction, pin_two_out_level, pin_two_irq_enable;
  logic pin_two_level_select, pin_two_buck_two_ctrl, pin_three_direction;
  logic pin_three_out_level, conv_trigger_enable, conv_trigger_edge_select;
  logic host_buck_one_on, host_buck_two_on, host_standby, irq_n, irq_d;
  logic buck_one_on, buck_two_on, buck_standby, conv_start;
  logic [1:0] q[$];
  logic [1:0] note;
  logic [31:0] rnd;
  int n_fail, cmp_count, cyc, m, i;
  gmc_gpio_override u_gmc_gpio_override (.*);
  gmc_pin_model u_gmc_pin_model (.pin_oe, .ext_low, .pin_level(pin_in));
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic cy(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic lv(logic [6:0] e);
    logic [6:0] got;
    cy(5);
    #1;
    got = {irq_n, buck_one_on, buck_two_on, buck_standby, pin_oe};
    `CHK("levels", e, got)
    // Back on the rising edge so the next drive lands there
    @(posedge clk_sys);
  endtask
  task automatic test_done();
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Clock; a stuck design is cut off by the cycle ceiling
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      test_done();
    end
  end
  // Each trigger pulse or interrupt fall takes the oldest note
  always @(negedge clk_sys) begin
    irq_d <= irq_n;
    if (resetn && (conv_start || (irq_d && !irq_n))) begin
      note = q.size() ? q.pop_front() : 2'h0;
      `CHK("event", note, {~irq_n, conv_start})
    end
  end
  initial begin
    {resetn, host_read, undervoltage_lockout, ext_low, pin_one_direction,
      pin_one_out_level, pin_one_irq_enable, pin_one_level_select,
      pin_one_buck_one_ctrl, pin_one_standby_ctrl, pin_two_direction,
      pin_two_out_level, pin_two_irq_enable, pin_two_level_select,
      pin_two_buck_two_ctrl, pin_three_direction, pin_three_out_level,
      conv_trigger_enable, conv_trigger_edge_select, host_buck_one_on,
      host_buck_two_on, host_standby} = '0;
    {clk_en, irq_d, rnd} = {2'h3, 32'h3b};
    cy(20);
    resetn <= 1'h1;
    // Output mode with random levels and host commands
    repeat (8) begin
      rnd = xs(rnd);
      @(posedge clk_sys);
      {pin_one_direction, pin_two_direction, pin_three_direction} <= 3'h7;
      {pin_one_out_level, pin_two_out_level, pin_three_out_level,
        host_buck_one_on, host_buck_two_on, host_standby} <= rnd[5:0];
      lv({1'h1, rnd[2:1], 1'h0, ~rnd[3], ~rnd[4], ~rnd[5]});
    end
    // one input function per pin at a time
    for (m = 0; m < 3; m++)
      for (i = 0; i < 4; i++) begin
        @(posedge clk_sys);
        {pin_one_direction, pin_two_direction, pin_three_direction} <= 3'h0;
        {host_buck_one_on, host_buck_two_on, host_standby} <= 3'h7;
        {pin_one_buck_one_ctrl, pin_two_buck_two_ctrl} <= {m == 0, m == 1};
        pin_one_standby_ctrl <= m == 2;
        {pin_one_level_select, pin_two_level_select} <= {2{i[1]}};
        ext_low <= {1'h0, {2{~i[0]}}};
        cy(5);
        lv({1'h1, m != 0 || i[0] == i[1], m != 1 || i[0] == i[1],
          m == 2 && i[0] == i[1], 3'h0});
      end
    // Conversion trigger, each edge select, both edges offered
    {pin_one_standby_ctrl, conv_trigger_enable} <= 2'h1;
    for (i = 0; i < 2; i++) begin
      conv_trigger_edge_select <= i[0];
      cy(10);
      if (!i[0]) q.push_back(2'h1);
      ext_low[2] <= 1'h1;
      cy(12);
      if (i[0]) q.push_back(2'h1);
      ext_low[2] <= 1'h0;
      cy(12);
    end
    // Pin one interrupt on falling edges, cleared by a late read
    {pin_one_irq_enable, pin_one_level_select} <= 2'h3;
    cy(10);
    q.push_back(2'h2);
    ext_low[0] <= 1'h1;
    cy(10);
    ext_low[0] <= 1'h0;
    host_read <= 1'h1;
    @(posedge clk_sys);
    host_read <= 1'h0;
    lv(7'h30);
    ext_low[0] <= 1'h1;
    cy(10);
    host_read <= 1'h1;
    @(posedge clk_sys);
    host_read <= 1'h0;
    lv(7'h70);
    // Pin two on rising edges, cleared by lockout then by output mode
    {pin_one_irq_enable, pin_two_irq_enable, pin_two_level_select} <= 3'h2;
    for (i = 0; i < 2; i++) begin
      ext_low[1] <= 1'h1;
      cy(10);
      q.push_back(2'h2);
      ext_low[1] <= 1'h0;
      lv(7'h30);
      if (i == 0) undervoltage_lockout <= 1'h1;
      else {pin_two_direction, pin_two_out_level} <= 2'h3;
      @(posedge clk_sys);
      undervoltage_lockout <= 1'h0;
      lv(7'h70);
    end
    `CHK("notes left", 32'h0, q.size())
    test_done();
  end
endmodule
